// ==== ucr_bank.sv ====
// Channel register bank with receive trigger interrupt and reset pin states
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Function
// [RULE_01] The receive threshold register takes an 8-bit value setting a level of zero to 64.
// [RULE_02] A receive interrupt is requested once the FIFO level climbs to the threshold.
// [RULE_03] The threshold register is write-only and reads never return it.
// [RULE_04] On reset modem state shows input levels in bits 7-4 and clears bits 3-0; here reset clears all eight bits and levels show three clocks after release.
// [RULE_05] On reset the interrupt source register reads 0x01.
// [RULE_06] On reset the line state register reads 0x60.
// [RULE_07] On reset the scratchpad register holds all ones.
// [RULE_08] On reset the control, feature, count, trigger and character registers clear to zero.
// [RULE_09] Reset leaves the divisor and holding registers undefined; this bank clears them to zero.
// [RULE_10] From reset serial output is high and infrared output is low.
// [RULE_11] From reset the active-low request and ready outputs are high.
// [RULE_12] The receive level count reports 0 to 64 bytes, is read-only and feeds the compare.
// [RULE_13] The trigger condition clears below threshold and reaches the output only if enabled.
module ucr_bank (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [6:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Receive byte injection from the line side
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    // Modem inputs, active low pins
    input wire logic [3:0] i_modem_n,
    // Serial and modem outputs
    output logic o_serial_out,
    output logic o_infrared_out,
    output logic o_request_to_send_n,
    output logic o_terminal_ready_n,
    // Transmit byte written by software
    output logic [7:0] o_tx_byte,
    output logic o_tx_load,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        ucr_pkg::ucr_cfg_t cfg;
        ucr_pkg::ucr_modem_t modem_state_reg;
        logic [7:0] line_state_reg;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic trig_prev;
        logic [3:0] msync1;
        logic [3:0] msync2;
        logic [3:0] mlvl_prev;
        logic [2:0] mseed;
        logic [31:0] rdata;
        logic ack;
        logic tx_load;
        logic rx_sync1;
        logic rx_sync2;
        logic rx_prev;
        logic [7:0] rxb1;
        logic [7:0] rxb2;
    } ucr_bank_st_t;

    ucr_bank_st_t st;
    ucr_bank_st_t next_st;
    logic req;
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [7:0] wbyte;
    logic fifo_rd;
    logic fifo_wr;
    logic [7:0] fifo_data;
    logic [7:0] rx_level;
    logic fifo_ovf;
    logic trig_hit;
    logic [7:0] isr_val;

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                              input logic sel);
        merge_byte = sel ? nw : old;
    endfunction

    ucr_fifo u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(fifo_wr),
        .i_wdata(st.rxb2),
        .i_rd(fifo_rd),
        .o_rdata(fifo_data),
        .o_level(rx_level),
        .o_overflow(fifo_ovf)
    );

    always_comb begin
        req = i_wb_cyc && i_wb_stb && !st.ack;
        wr = req && i_wb_we;
        rd = req && !i_wb_we;
        idx = i_wb_adr[6:2];
        wbyte = i_wb_dat[7:0];
        fifo_rd = rd && ((idx == ucr_pkg::IDX_FIFO_PORT) || (idx == ucr_pkg::IDX_RX_HOLD));
        // Rising edge of the synchronised strobe; the byte was staged with it
        fifo_wr = st.rx_sync2 && !st.rx_prev;
        // Threshold of zero counts as met even while empty
        trig_hit = (rx_level >= st.cfg.rx_thr); // see [RULE_02] see [RULE_12] see [RULE_13]
        isr_val = (trig_hit && st.cfg.interrupt_enable_reg[ucr_pkg::IER_RX_BIT]) ?
                  ucr_pkg::ISR_RX_TRIG : ucr_pkg::ISR_NONE; // see [RULE_05]
    end

    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.tx_load = 1'b0;
        next_st.rdata = 32'h0000_0000;
        next_st.rx_sync1 = i_rx_valid;
        next_st.rx_sync2 = st.rx_sync1;
        next_st.rx_prev = st.rx_sync2;
        next_st.rxb1 = i_rx_byte;
        next_st.rxb2 = st.rxb1;
        next_st.msync1 = ~i_modem_n;
        next_st.msync2 = st.msync1;
        next_st.mlvl_prev = st.msync2;
        // Change bits wait until the edge history holds real pin levels, so no false edge
        next_st.mseed = {st.mseed[1:0], 1'b1};
        next_st.trig_prev = trig_hit;

        // Modem state: level bits follow inputs, change bits collect edges
        next_st.modem_state_reg.lvl = st.msync2; // see [RULE_04]
        if (st.mseed[2]) begin
            next_st.modem_state_reg.delta = st.modem_state_reg.delta | (st.msync2 ^ st.mlvl_prev);
        end

        // Line state: data ready follows level, overrun is sticky until read
        next_st.line_state_reg[ucr_pkg::LSR_DR_BIT] = (rx_level != 8'h00);
        if (fifo_ovf) begin
            next_st.line_state_reg[ucr_pkg::LSR_OE_BIT] = 1'b1;
        end

        if (rd) begin
            case (idx)
                ucr_pkg::IDX_RX_HOLD: next_st.rdata[7:0] = fifo_data;
                ucr_pkg::IDX_IER: next_st.rdata[7:0] = st.cfg.interrupt_enable_reg;
                ucr_pkg::IDX_ISR_FCR: next_st.rdata[7:0] = isr_val;
                ucr_pkg::IDX_LCR: next_st.rdata[7:0] = st.cfg.line_control_reg;
                ucr_pkg::IDX_MCR: next_st.rdata[7:0] = st.cfg.modem_control_reg;
                ucr_pkg::IDX_LSR: begin
                    next_st.rdata[7:0] = st.line_state_reg;
                    next_st.line_state_reg[ucr_pkg::LSR_OE_BIT] = fifo_ovf;
                end
                ucr_pkg::IDX_MSR: begin
                    next_st.rdata[7:0] = st.modem_state_reg;
                    next_st.modem_state_reg.delta = st.mseed[2] ? (st.msync2 ^ st.mlvl_prev) : 4'h0;
                end
                ucr_pkg::IDX_SPR: next_st.rdata[7:0] = st.cfg.scratchpad_reg;
                ucr_pkg::IDX_FEATURE_CONTROL_REG: next_st.rdata[7:0] = st.cfg.feature_control_reg;
                ucr_pkg::IDX_EFR: next_st.rdata[7:0] = st.cfg.enhanced_feature_reg;
                ucr_pkg::IDX_TX_FIFO_LEVEL_COUNT_TRG: next_st.rdata[7:0] = 8'h00;
                // Reads give the level count, never the threshold
                ucr_pkg::IDX_RX_FIFO_LEVEL_COUNT_TRG: next_st.rdata[7:0] = rx_level; // see [RULE_03] see [RULE_12]
                ucr_pkg::IDX_FLOW_CHAR_STATUS: next_st.rdata[7:0] = st.cfg.flow_char_status;
                ucr_pkg::IDX_RESUME_CHAR_FIRST: next_st.rdata[7:0] = st.cfg.resume_char_first;
                ucr_pkg::IDX_RESUME_CHAR_SECOND: next_st.rdata[7:0] = st.cfg.resume_char_second;
                ucr_pkg::IDX_PAUSE_CHAR_FIRST: next_st.rdata[7:0] = st.cfg.pause_char_first;
                ucr_pkg::IDX_PAUSE_CHAR_SECOND: next_st.rdata[7:0] = st.cfg.pause_char_second;
                ucr_pkg::IDX_DLL: next_st.rdata[7:0] = st.cfg.dll;
                ucr_pkg::IDX_DLM: next_st.rdata[7:0] = st.cfg.divisor_high;
                ucr_pkg::IDX_IRQ_STAT: next_st.rdata[2:0] = st.irq_stat;
                ucr_pkg::IDX_IRQ_MASK: next_st.rdata[2:0] = st.irq_mask;
                ucr_pkg::IDX_FIFO_PORT: next_st.rdata[7:0] = fifo_data;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        if (wr && i_wb_sel[0]) begin
            case (idx)
                ucr_pkg::IDX_RX_HOLD: begin
                    next_st.cfg.tx_hold = wbyte;
                    next_st.tx_load = 1'b1;
                end
                ucr_pkg::IDX_IER: next_st.cfg.interrupt_enable_reg = wbyte;
                ucr_pkg::IDX_ISR_FCR: next_st.cfg.fifo_control_reg = wbyte;
                ucr_pkg::IDX_LCR: next_st.cfg.line_control_reg = wbyte;
                ucr_pkg::IDX_MCR: next_st.cfg.modem_control_reg = wbyte;
                ucr_pkg::IDX_SPR: next_st.cfg.scratchpad_reg = wbyte;
                ucr_pkg::IDX_FEATURE_CONTROL_REG: next_st.cfg.feature_control_reg = wbyte;
                ucr_pkg::IDX_EFR: next_st.cfg.enhanced_feature_reg = wbyte;
                ucr_pkg::IDX_TX_FIFO_LEVEL_COUNT_TRG: next_st.cfg.tx_thr = wbyte;
                // Values above 64 are stored but never met by a full FIFO
                ucr_pkg::IDX_RX_FIFO_LEVEL_COUNT_TRG: next_st.cfg.rx_thr = wbyte; // see [RULE_01]
                ucr_pkg::IDX_FLOW_CHAR_STATUS: next_st.cfg.flow_char_status = wbyte;
                ucr_pkg::IDX_RESUME_CHAR_FIRST: next_st.cfg.resume_char_first = wbyte;
                ucr_pkg::IDX_RESUME_CHAR_SECOND: next_st.cfg.resume_char_second = wbyte;
                ucr_pkg::IDX_PAUSE_CHAR_FIRST: next_st.cfg.pause_char_first = wbyte;
                ucr_pkg::IDX_PAUSE_CHAR_SECOND: next_st.cfg.pause_char_second = wbyte;
                ucr_pkg::IDX_DLL: next_st.cfg.dll = wbyte;
                ucr_pkg::IDX_DLM: next_st.cfg.divisor_high = wbyte;
                ucr_pkg::IDX_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wbyte[2:0];
                ucr_pkg::IDX_IRQ_MASK: next_st.irq_mask = wbyte[2:0] & ucr_pkg::IRQ_W_MASK;
                default: next_st.rdata = next_st.rdata;
            endcase
        end

        // Events set after any clear so a same-cycle event survives
        if (trig_hit && !st.trig_prev && st.cfg.interrupt_enable_reg[ucr_pkg::IER_RX_BIT]) begin
            next_st.irq_stat[ucr_pkg::IRQ_TRIG_BIT] = 1'b1; // see [RULE_02] see [RULE_13]
        end
        if (fifo_ovf) begin
            next_st.irq_stat[ucr_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (st.mseed[2] && ((st.msync2 ^ st.mlvl_prev) != 4'h0)) begin
            next_st.irq_stat[ucr_pkg::IRQ_MODEM_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0; // see [RULE_08]
            st.cfg.scratchpad_reg <= ucr_pkg::RST_SPR; // see [RULE_07]
            st.line_state_reg <= ucr_pkg::RST_LSR; // see [RULE_06]
            st.cfg.rx_thr <= ucr_pkg::RST_ZERO; // see [RULE_08]
            // Divisors and holding byte clear here only for determinism; software must program
            st.cfg.dll <= ucr_pkg::RST_ZERO; // see [RULE_09]
            st.cfg.divisor_high <= ucr_pkg::RST_ZERO; // see [RULE_09]
        end else begin
            st <= next_st;
        end
    end

    // Level trigger while enabled; unmasked sticky bits join it
    assign o_irq = (trig_hit && st.cfg.interrupt_enable_reg[ucr_pkg::IER_RX_BIT]) ||
                   ((st.irq_stat & st.irq_mask) != 3'h0); // see [RULE_13]
    // Transmit path idles at mark; no serialiser drives it in this bank
    assign o_serial_out = 1'b1; // see [RULE_10]
    assign o_infrared_out = 1'b0; // see [RULE_10]
    // Modem control bits 1 and 0 assert the active-low outputs, clear after reset
    assign o_request_to_send_n = ~st.cfg.modem_control_reg[1]; // see [RULE_11]
    assign o_terminal_ready_n = ~st.cfg.modem_control_reg[0]; // see [RULE_11]
    assign o_tx_byte = st.cfg.tx_hold;
    assign o_tx_load = st.tx_load;
    assign o_wb_dat = st.rdata;
    assign o_wb_ack = st.ack;
endmodule

// ==== ucr_bank_assertions.sv ====
// Checker: bus answer and reset-state properties of the channel register bank
`timescale 1ns/1ps
module ucr_bank_assertions (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bus and modem inputs
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [6:0] i_wb_adr,
    input wire logic [3:0] i_modem_n,
    // Observed outputs
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_serial_out,
    input wire logic o_infrared_out,
    input wire logic o_request_to_send_n,
    input wire logic o_terminal_ready_n,
    input wire logic o_tx_load
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [4:0] idx;
    logic rd_ack;
    assign idx = i_wb_adr[6:2];
    assign rd_ack = o_wb_ack && !i_wb_we;
    sequence s_req; $rose(i_wb_cyc && i_wb_stb); endsequence
    sequence s_ans; o_wb_ack ##1 !o_wb_ack; endsequence
    // Modem pins need time to pass the synchroniser before a read can show them
    sequence s_calm; $stable(i_modem_n) [*5]; endsequence
    property p_ack; s_req |=> s_ans; endproperty
    property p_width; o_wb_ack |-> o_wb_dat[31:8] == 24'h000000; endproperty
    property p_rx_fifo_level_count;
        rd_ack && idx == ucr_pkg::IDX_RX_FIFO_LEVEL_COUNT_TRG |-> o_wb_dat[7:0] <= ucr_pkg::FIFO_DEPTH;
    endproperty
    property p_isr;
        rd_ack && idx == ucr_pkg::IDX_ISR_FCR |->
            o_wb_dat[7:0] == ucr_pkg::ISR_NONE || o_wb_dat[7:0] == ucr_pkg::ISR_RX_TRIG;
    endproperty
    property p_msr;
        s_calm ##0 (rd_ack && idx == ucr_pkg::IDX_MSR) |-> o_wb_dat[7:4] == ~i_modem_n;
    endproperty
    property p_line; o_serial_out && !o_infrared_out; endproperty
    property p_rst_pins; $fell(i_rst) |-> o_request_to_send_n && o_terminal_ready_n; endproperty
    property p_tx_load;
        o_tx_load |-> o_wb_ack && i_wb_we && idx == ucr_pkg::IDX_RX_HOLD;
    endproperty
    a_ack: assert property (p_ack) else $error("ack late or long");
    a_width: assert property (p_width) else $error("data above byte");
    a_rx_fifo_level_count: assert property (p_rx_fifo_level_count) else $error("level above 64");
    a_isr: assert property (p_isr) else $error("bad source code");
    a_msr: assert property (p_msr) else $error("modem levels wrong");
    a_line: assert property (p_line) else $error("serial idle wrong");
    a_rst_pins: assert property (p_rst_pins) else $error("handshake low");
    a_tx_load: assert property (p_tx_load) else $error("stray tx load");
endmodule

// ==== ucr_bank_tb.sv ====
// Testbench for the channel register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module ucr_bank_tb;
    typedef struct {logic [4:0] idx; logic [7:0] val;} ucr_row_t;
    logic i_clk = 1'b0, i_rst = 1'b1, rx_valid = 1'b0, irq, ack, cyc, stb, we;
    logic ser, ir, rts_n, dtr_n, tx_load;
    logic [7:0] rx_byte = 8'h00, tx_byte, v;
    logic [3:0] modem_n = 4'hF, sel;
    logic [6:0] adr;
    logic [31:0] wdat, rdat;
    int errors = 0, check_count = 0;
    ucr_row_t rows [18] = '{'{5'h01, 8'h00}, '{5'h02, 8'h01}, '{5'h03, 8'h00},
        '{5'h04, 8'h00}, '{5'h05, 8'h60}, '{5'h06, 8'h00}, '{5'h07, 8'hFF}, '{5'h08, 8'h00},
        '{5'h09, 8'h00}, '{5'h0A, 8'h00}, '{5'h0B, 8'h00}, '{5'h0C, 8'h00}, '{5'h0D, 8'h00},
        '{5'h0E, 8'h00}, '{5'h0F, 8'h00}, '{5'h10, 8'h00}, '{5'h13, 8'h00}, '{5'h14, 8'h00}};
    ucr_host_model u_host (.i_clk(i_clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
        .o_sel(sel), .o_dat(wdat), .i_dat(rdat), .i_ack(ack));
    ucr_bank DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_modem_n(modem_n), .o_serial_out(ser),
        .o_infrared_out(ir), .o_request_to_send_n(rts_n), .o_terminal_ready_n(dtr_n),
        .o_tx_byte(tx_byte), .o_tx_load(tx_load), .o_irq(irq));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, idx, d, v);
    endtask
    task automatic rd(input logic [4:0] idx);
        u_host.xfer(1'b0, idx, 8'h00, v);
    endtask
    // Byte held steady around the strobe so the synchroniser captures it cleanly
    task automatic push(input logic [7:0] b);
        rx_byte <= b;
        repeat (2) @(posedge i_clk);
        rx_valid <= 1'b1;
        repeat (3) @(posedge i_clk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic rst_rows();
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        `CHK("reset pins", 4'hD, {ser, rts_n, ir, dtr_n})
        `CHK("reset handshake", 2'h3, {rts_n, dtr_n})
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            rd(rows[i].idx);
            `CHK("reset", rows[i].val, v)
        end
        $display("reset values done");
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        print_verdict;
    end
    initial begin
        rst_rows();
        wr(5'h0B, 8'h03);
        rd(5'h0B);
        `CHK("threshold read", 8'h00, v)
        wr(5'h01, 8'h01);
        push(8'hA0);
        push(8'hA1);
        `CHK("irq below", 1'b0, irq)
        push(8'hA2);
        `CHK("irq at level", 1'b1, irq)
        rd(5'h02);
        `CHK("source trig", 8'h04, v)
        rd(5'h0B);
        `CHK("level", 8'h03, v)
        rd(5'h00);
        `CHK("pop", 8'hA0, v)
        @(negedge i_clk);
        `CHK("irq cleared", 1'b0, irq)
        rd(5'h13);
        `CHK("sticky", 8'h01, v)
        wr(5'h14, 8'h01);
        @(negedge i_clk);
        `CHK("masked on", 1'b1, irq)
        wr(5'h13, 8'h01);
        // Enable goes off first, so the lower threshold cannot latch a new sticky trigger
        wr(5'h01, 8'h00);
        wr(5'h0B, 8'h02);
        @(negedge i_clk);
        `CHK("irq disabled", 1'b0, irq)
        $display("trigger test done");
        wr(5'h0B, 8'h40);
        repeat (62) push(8'h55);
        rd(5'h0B);
        `CHK("full level", 8'h40, v)
        push(8'h66);
        rd(5'h05);
        `CHK("overrun", 8'h63, v)
        rd(5'h13);
        `CHK("ovf stat", 8'h02, v)
        wr(5'h01, 8'h01);
        @(negedge i_clk);
        `CHK("irq at 64", 1'b1, irq)
        $display("full test done");
        wr(5'h07, 8'h5A);
        rd(5'h07);
        `CHK("scratch", 8'h5A, v)
        wr(5'h00, 8'h3C);
        `CHK("tx byte", 8'h3C, tx_byte)
        rd(5'h1F);
        `CHK("unmapped", 8'h00, v)
        wr(5'h04, 8'h03);
        @(negedge i_clk);
        `CHK("handshake on", 2'h0, {rts_n, dtr_n})
        @(posedge i_clk);
        modem_n <= 4'h5;
        repeat (6) @(posedge i_clk);
        rd(5'h06);
        `CHK("modem lvl", 4'hA, v[7:4])
        modem_n <= 4'hF;
        $display("misc test done");
        rst_rows();
        print_verdict;
    end
endmodule
bind ucr_bank ucr_bank_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_modem_n(i_modem_n),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_serial_out(o_serial_out),
    .o_infrared_out(o_infrared_out), .o_request_to_send_n(o_request_to_send_n),
    .o_terminal_ready_n(o_terminal_ready_n), .o_tx_load(o_tx_load));

// ==== ucr_fifo.sv ====
// Receive byte store with level count for one channel
`timescale 1ns/1ps
module ucr_fifo (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Write side
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    // Read side
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Status
    output logic [7:0] o_level,
    output logic o_overflow
);
    typedef struct packed {
        logic [5:0] wp;
        logic [5:0] rp;
        logic [7:0] level;
        logic [7:0] rdata;
        logic ovf;
    } ucr_fifo_st_t;

    ucr_fifo_st_t st;
    ucr_fifo_st_t next_st;
    logic [7:0] mem [0:63];
    logic do_wr;
    logic do_rd;

    always_comb begin
        do_rd = i_rd && (st.level != 8'h00);
        do_wr = i_wr && ((st.level != ucr_pkg::FIFO_DEPTH) || do_rd);
        next_st = st;
        next_st.ovf = i_wr && !do_wr;
        if (do_wr) begin
            next_st.wp = st.wp + 6'h01;
        end
        if (do_rd) begin
            next_st.rp = st.rp + 6'h01;
            next_st.rdata = mem[st.rp];
        end
        if (do_wr && !do_rd) begin
            next_st.level = st.level + 8'h01;
        end else if (do_rd && !do_wr) begin
            next_st.level = st.level - 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage holds no reset: contents are undefined until written
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[st.wp] <= i_wdata;
        end
    end

    // Head byte shows before the pop so a read returns it in its own answer; empty repeats last
    assign o_rdata = (st.level != 8'h00) ? mem[st.rp] : st.rdata;
    assign o_level = st.level;
    assign o_overflow = st.ovf;
endmodule

// ==== ucr_host_model.sv ====
// Host processor model: classic single-cycle bus master
`timescale 1ns/1ps
module ucr_host_model (
    // Clock
    input wire logic i_clk,
    // Bus master signals
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [6:0] o_adr,
    output logic [3:0] o_sel,
    output logic [31:0] o_dat,
    input wire logic [31:0] i_dat,
    input wire logic i_ack
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 7'h00;
        o_sel = 4'h0;
        o_dat = 32'h00000000;
    end
    // Waits without limit; only the bench watchdog ends a hung cycle
    task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge i_clk);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= w;
        o_adr <= {idx, 2'h0};
        o_sel <= 4'h1;
        o_dat <= {24'h000000, wd};
        do @(posedge i_clk); while (i_ack !== 1'b1);
        rd = i_dat[7:0];
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_dat <= ~o_dat;
    endtask
endmodule

// ==== ucr_pkg.sv ====
// Package: register map, reset values and carrier types for one UART channel register bank
package ucr_pkg;
    // Register word indices (byte address = index * 4)
    localparam logic [4:0] IDX_RX_HOLD = 5'h00;
    localparam logic [4:0] IDX_IER = 5'h01;
    localparam logic [4:0] IDX_ISR_FCR = 5'h02;
    localparam logic [4:0] IDX_LCR = 5'h03;
    localparam logic [4:0] IDX_MCR = 5'h04;
    localparam logic [4:0] IDX_LSR = 5'h05;
    localparam logic [4:0] IDX_MSR = 5'h06;
    localparam logic [4:0] IDX_SPR = 5'h07;
    localparam logic [4:0] IDX_FEATURE_CONTROL_REG = 5'h08;
    localparam logic [4:0] IDX_EFR = 5'h09;
    localparam logic [4:0] IDX_TX_FIFO_LEVEL_COUNT_TRG = 5'h0A;
    localparam logic [4:0] IDX_RX_FIFO_LEVEL_COUNT_TRG = 5'h0B;
    localparam logic [4:0] IDX_FLOW_CHAR_STATUS = 5'h0C;
    localparam logic [4:0] IDX_RESUME_CHAR_FIRST = 5'h0D;
    localparam logic [4:0] IDX_RESUME_CHAR_SECOND = 5'h0E;
    localparam logic [4:0] IDX_PAUSE_CHAR_FIRST = 5'h0F;
    localparam logic [4:0] IDX_PAUSE_CHAR_SECOND = 5'h10;
    localparam logic [4:0] IDX_DLL = 5'h11;
    localparam logic [4:0] IDX_DLM = 5'h12;
    localparam logic [4:0] IDX_IRQ_STAT = 5'h13;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h14;
    localparam logic [4:0] IDX_FIFO_PORT = 5'h15;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ISR = 8'h01;
    localparam logic [7:0] RST_LSR = 8'h60;
    localparam logic [7:0] RST_SPR = 8'hFF;

    // Field positions and limits
    localparam int IER_RX_BIT = 0;
    localparam int LSR_DR_BIT = 0;
    localparam int LSR_OE_BIT = 1;
    localparam int IRQ_TRIG_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int IRQ_MODEM_BIT = 2;
    localparam logic [7:0] FIFO_DEPTH = 8'h40;
    localparam logic [7:0] ISR_RX_TRIG = 8'h04;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [2:0] IRQ_W_MASK = 3'h7;

    typedef struct packed {
        logic [7:0] interrupt_enable_reg;
        logic [7:0] fifo_control_reg;
        logic [7:0] line_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] scratchpad_reg;
        logic [7:0] feature_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] tx_thr;
        logic [7:0] rx_thr;
        logic [7:0] flow_char_status;
        logic [7:0] resume_char_first;
        logic [7:0] resume_char_second;
        logic [7:0] pause_char_first;
        logic [7:0] pause_char_second;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic [7:0] tx_hold;
    } ucr_cfg_t;

    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] delta;
    } ucr_modem_t;
endpackage
